//--- hdl/dac_debug_comparators.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Comparator A high byte is the match value for address bits 15 to 8.
// - Comparator A low byte is the match value for address bits 7 to 0.
// - Comparator B high byte matches address 15 to 8; ignored in full mode.
// - Comparator B low byte matches address 7 to 0, or data 7 to 0 in full mode.
// - Comparator C high byte is the match value for address bits 15 to 8.
// - Comparator C low byte is the match value for address bits 7 to 0.
// - Stored 0 needs the bus bit low, stored 1 needs it high.
// - End-run reset with unit enabled and end-trace selected keeps comparator, control and trace values; match status clears.
// - Trace high byte read returns bits 15 to 8 of the current word.
// - In event-only modes the trace high byte reads as zero.
// - Full mode: A compares address, B data; dual mode: both compare addresses.
// - Reading the trace low byte advances the read pointer to the next word.
// - Event-only modes store comparator B event data, not change-of-flow addresses.
module dac_debug_comparators #(
    parameter int DEPTH = 8
) (
    input  logic                      sys_clk,
    input  logic                      sys_rst,
    input  logic                      por_rst,
    input  dac_pkg::dac_cpu_bus_t     cpu,
    output dac_pkg::dac_match_t       match,
    input  logic [dac_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  logic                      s_axi_awvalid,
    output logic                      s_axi_awready,
    input  logic [31:0]               s_axi_wdata,
    input  logic [3:0]                s_axi_wstrb,
    input  logic                      s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  logic                      s_axi_bready,
    input  logic [dac_pkg::AXI_AW-1:0] s_axi_araddr,
    input  logic                      s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  logic                      s_axi_rready
);
    import dac_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Reset qualification
    logic [7:0]       cah_r, cal_r, cbh_r, cbl_r, cch_r, ccl_r, ctrl_r;
    logic             unit_en, full_mode, event_mode, end_run;
    logic             keep_all, reload, bus_rst;

    assign unit_en    = ctrl_r[CTL_EN];
    assign full_mode  = ctrl_r[CTL_FULL];
    assign event_mode = ctrl_r[CTL_EVT];
    assign end_run    = unit_en && !ctrl_r[CTL_BEGIN];
    assign keep_all   = sys_rst && !por_rst && end_run;
    assign reload     = por_rst || (sys_rst && !end_run);
    assign bus_rst    = sys_rst || por_rst;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic                 aw_held_r, w_held_r, bvalid_r;
    logic [IDX_W-1:0]     aw_idx_r;
    logic [7:0]           wdat_r;
    logic                 wlane_r;
    logic [1:0]           bresp_r;
    logic                 wr_go;

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        idx_mapped = (idx <= IDX_FL) || (idx == IDX_CTRL) || (idx == IDX_STAT)
                     || (idx == IDX_CNT);
    endfunction : idx_mapped

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign wr_go         = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge sys_clk) begin
        if (bus_rst) begin
            aw_held_r <= 1'b0;
            aw_idx_r  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[AXI_AW-1:2];
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (bus_rst) begin
            w_held_r <= 1'b0;
            wdat_r   <= '0;
            wlane_r  <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdat_r   <= s_axi_wdata[7:0];
            wlane_r  <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (bus_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= idx_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparator value and control registers
    // Writes are shut out while an end-run reset keeps the values
    logic reg_we;
    assign reg_we = wr_go && wlane_r;

    always_ff @(posedge sys_clk) begin
        if (reload) begin
            cah_r  <= RST_CAH;
            cal_r  <= RST_CAL;
            cbh_r  <= RST_CBH;
            cbl_r  <= RST_CBL;
            cch_r  <= RST_CCH;
            ccl_r  <= RST_CCL;
            ctrl_r <= RST_CTRL;
        end else if (!keep_all && reg_we) begin
            case (aw_idx_r)
                IDX_CAH:  cah_r  <= wdat_r;
                IDX_CAL:  cal_r  <= wdat_r;
                IDX_CBH:  cbh_r  <= wdat_r;
                IDX_CBL:  cbl_r  <= wdat_r;
                IDX_CCH:  cch_r  <= wdat_r;
                IDX_CCL:  ccl_r  <= wdat_r;
                IDX_CTRL: ctrl_r <= {4'h0, wdat_r[3:0]};
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparators, sampled one cycle after the CPU bus cycle
    dac_match_t match_r;
    dac_match_t hit;

    always_comb begin
        hit.a = cpu.valid && unit_en && (cpu.addr == {cah_r, cal_r});
        hit.b = cpu.valid && unit_en && (full_mode ? (cpu.data == cbl_r)
                                                   : (cpu.addr == {cbh_r, cbl_r}));
        hit.c = cpu.valid && unit_en && (cpu.addr == {cch_r, ccl_r});
    end

    logic [15:0] addr_q_r;
    logic [7:0]  data_q_r;
    logic        cof_q_r;

    always_ff @(posedge sys_clk) begin
        if (bus_rst) begin
            match_r  <= '0;
            addr_q_r <= '0;
            data_q_r <= '0;
            cof_q_r  <= 1'b0;
        end else begin
            match_r  <= hit;
            addr_q_r <= cpu.addr;
            data_q_r <= cpu.data;
            cof_q_r  <= cpu.valid && cpu.cof;
        end
    end

    assign match = match_r;

    ////////////////////////////////////////////////////////////////////////////
    // Trace buffer
    logic [15:0]      mem_r [DEPTH];
    logic [PTR_W-1:0] wptr_r, rptr_r;
    logic [PTR_W:0]   cnt_r;
    logic             push, pop, not_full, not_empty;
    logic [15:0]      push_word, head;
    logic             ar_hs;

    assign ar_hs     = s_axi_arvalid && s_axi_arready;
    assign not_full  = cnt_r != (PTR_W+1)'(DEPTH);
    assign not_empty = cnt_r != '0;
    assign head      = mem_r[rptr_r];
    // Event mode stores comparator B data, otherwise change-of-flow addresses
    assign push      = unit_en && not_full && (event_mode ? match_r.b : cof_q_r);
    assign push_word = event_mode ? {8'h00, data_q_r} : addr_q_r;
    assign pop       = ar_hs && (s_axi_araddr[AXI_AW-1:2] == IDX_FL) && not_empty;

    always_ff @(posedge sys_clk) begin
        if (reload) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else if (!keep_all) begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reload) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (!keep_all && push) begin
            mem_r[wptr_r] <= push_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [7:0]  rd_val;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_comb begin
        rd_val = 8'h00;
        case (s_axi_araddr[AXI_AW-1:2])
            IDX_CAH:  rd_val = cah_r;
            IDX_CAL:  rd_val = cal_r;
            IDX_CBH:  rd_val = cbh_r;
            IDX_CBL:  rd_val = cbl_r;
            IDX_CCH:  rd_val = cch_r;
            IDX_CCL:  rd_val = ccl_r;
            IDX_FH:   rd_val = (not_empty && !event_mode) ? head[15:8] : 8'h00;
            IDX_FL:   rd_val = not_empty ? head[7:0] : 8'h00;
            IDX_CTRL: rd_val = ctrl_r;
            IDX_STAT: rd_val = {5'h00, match_r};
            IDX_CNT:  rd_val = 8'((PTR_W+1)'(cnt_r));
            default:  rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (bus_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h000000, rd_val};
            rresp_r  <= idx_mapped(s_axi_araddr[AXI_AW-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (bus_rst);

    sequence s_hi_read;
        ar_hs && (s_axi_araddr[AXI_AW-1:2] == IDX_FH);
    endsequence

    sequence s_lo_pop_alone;
        pop && !push;
    endsequence

    a_match_a_addr: assert property (
        (cpu.valid && unit_en && cpu.addr[15:8] != cah_r) |=> !match.a)
        else $error("comparator A matched with wrong high byte");

    a_match_a_low: assert property (
        (cpu.valid && unit_en && cpu.addr == {cah_r, cal_r}) |=> match.a)
        else $error("comparator A missed an exact address");

    a_match_b_full: assert property (
        (cpu.valid && unit_en && full_mode && cpu.data == cbl_r
         && cpu.addr[15:8] != cbh_r) |=> match.b)
        else $error("comparator B high byte used in full mode");

    a_match_b_dual: assert property (
        (cpu.valid && unit_en && !full_mode && cpu.addr[7:0] != cbl_r) |=> !match.b)
        else $error("comparator B matched wrong address in dual mode");

    a_match_c_addr: assert property (
        (cpu.valid && unit_en && cpu.addr == {cch_r, ccl_r}) |=> match.c ##1 1'b1)
        else $error("comparator C missed an exact address");

    a_match_c_low: assert property (
        (cpu.valid && unit_en && cpu.addr[7:0] != ccl_r) |=> !match.c)
        else $error("comparator C matched with wrong low byte");

    a_bit_polarity: assert property (
        (cpu.valid && unit_en && (cpu.addr ^ {cah_r, cal_r}) != 16'h0000) |=> !match.a)
        else $error("comparator matched an inverted bit");

    a_endrun_hold: assert property (@(posedge sys_clk) disable iff (1'b0)
        keep_all |=> (cah_r == $past(cah_r)) && (ccl_r == $past(ccl_r))
                     && (cnt_r == $past(cnt_r)) && (rptr_r == $past(rptr_r)))
        else $error("end-run reset changed a retained register");

    a_trace_high: assert property (
        (s_hi_read and (not_empty && !event_mode)) |=> rdata_r[7:0] == $past(head[15:8]))
        else $error("trace high byte read wrong data");

    a_event_high_zero: assert property (
        (s_hi_read and event_mode) |=> s_axi_rvalid && rdata_r == 32'h00000000)
        else $error("trace high byte nonzero in event mode");

    a_full_uses_data: assert property (
        (cpu.valid && unit_en && full_mode && cpu.data != cbl_r) |=> !match.b)
        else $error("comparator B ignored data in full mode");

    a_low_read_pop: assert property (
        s_lo_pop_alone |=> (cnt_r == $past(cnt_r) - 1'b1)
                           && (rptr_r == $past(rptr_r) + 1'b1))
        else $error("low byte read did not advance the buffer");

    a_empty_no_pop: assert property (
        (ar_hs && (s_axi_araddr[AXI_AW-1:2] == IDX_FL) && !not_empty && !push)
        |=> (cnt_r == $past(cnt_r)) && (rptr_r == $past(rptr_r)))
        else $error("empty low byte read moved the buffer");

    a_event_store: assert property (
        (push && event_mode) |=> mem_r[$past(wptr_r)] == {8'h00, $past(data_q_r)})
        else $error("event mode stored wrong trace word");

    a_por_reload: assert property (@(posedge sys_clk) disable iff (1'b0)
        por_rst |=> (cah_r == RST_CAH) && (ccl_r == RST_CCL) && (cnt_r == '0))
        else $error("power-on reset did not reload values");

endmodule : dac_debug_comparators

//--- hdl/dac_pkg.sv
package dac_pkg;
    // AXI byte address width; each register takes one aligned word
    localparam int AXI_AW = 8;
    localparam int IDX_W  = AXI_AW - 2;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CAH  = 6'h00;
    localparam logic [IDX_W-1:0] IDX_CAL  = 6'h01;
    localparam logic [IDX_W-1:0] IDX_CBH  = 6'h02;
    localparam logic [IDX_W-1:0] IDX_CBL  = 6'h03;
    localparam logic [IDX_W-1:0] IDX_CCH  = 6'h04;
    localparam logic [IDX_W-1:0] IDX_CCL  = 6'h05;
    localparam logic [IDX_W-1:0] IDX_FH   = 6'h06;
    localparam logic [IDX_W-1:0] IDX_FL   = 6'h07;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_STAT = 6'h0E;
    localparam logic [IDX_W-1:0] IDX_CNT  = 6'h0F;

    // Reload values on power-on or a non-end-run reset
    localparam logic [7:0] RST_CAH  = 8'hFF;
    localparam logic [7:0] RST_CAL  = 8'h00;
    localparam logic [7:0] RST_CBH  = 8'h00;
    localparam logic [7:0] RST_CBL  = 8'h00;
    localparam logic [7:0] RST_CCH  = 8'h00;
    localparam logic [7:0] RST_CCL  = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // Control register field positions
    localparam int CTL_EN    = 0;
    localparam int CTL_FULL  = 1;
    localparam int CTL_EVT   = 2;
    localparam int CTL_BEGIN = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        valid;
        logic        cof;
    } dac_cpu_bus_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } dac_match_t;
endpackage : dac_pkg

//--- tb/dac_cpu_model.sv
`timescale 1ns/1ps
module dac_cpu_model (
    input  logic                  sys_clk,
    input  logic                  go,
    input  logic [15:0]           go_addr,
    input  logic [7:0]            go_data,
    input  logic                  go_cof,
    output dac_pkg::dac_cpu_bus_t cpu
);
    import dac_pkg::*;
    initial cpu = '0;
    // One bus cycle per request; a released bus drops valid and cof and shows the inverse of its last address and data
    always @(posedge sys_clk) begin
        if (go) begin
            cpu <= '{addr: go_addr, data: go_data, valid: 1'b1, cof: go_cof};
        end else begin
            cpu <= '{addr: ~cpu.addr, data: ~cpu.data, valid: 1'b0, cof: 1'b0};
        end
    end
endmodule : dac_cpu_model

//--- tb/debug_address_comparators_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module debug_address_comparators_tb;
    import dac_pkg::*;
    localparam int BUF_DEPTH = 4;
    logic                  sys_clk, sys_rst, por_rst, go, go_cof;
    logic [15:0]           go_addr;
    logic [7:0]            go_data, seed, mctrl;
    logic [7:0]            mreg [0:5];
    logic [15:0]           mq [$];
    dac_cpu_bus_t          cpu;
    dac_match_t            match;
    logic [AXI_AW-1:0]     s_axi_awaddr, s_axi_araddr;
    logic [31:0]           s_axi_wdata, s_axi_rdata;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                  s_axi_rvalid, s_axi_rready;
    int                    errors = 0;
    int                    comparisons = 0;

    dac_cpu_model PART (.sys_clk(sys_clk), .go(go), .go_addr(go_addr), .go_data(go_data),
        .go_cof(go_cof), .cpu(cpu));
    dac_debug_comparators #(.DEPTH(BUF_DEPTH)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .por_rst(por_rst), .cpu(cpu), .match(match), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic axi_wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] rsp);
        logic aw_hs, w_hs, b_hs;
        int   n;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            n++;
        end while (!b_hs && n < 50);
        if (!b_hs) errors++;
    endtask : axi_wr

    task automatic axi_rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] rsp);
        logic ar_hs, r_hs;
        int   n;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge sys_clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            n++;
        end while (!r_hs && n < 50);
        if (!r_hs) errors++;
    endtask : axi_rd

    task automatic wreg(input logic [5:0] idx, input logic [7:0] v);
        logic [1:0] rsp, er;
        er = (idx <= IDX_FL || idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_CNT)
             ? RESP_OKAY : RESP_SLVERR;
        axi_wr(idx, v, rsp);
        `CHK("bresp", er, rsp)
        if (idx <= 6'h05 && s_axi_wstrb[0]) mreg[idx] = v;
        if (idx == IDX_CTRL && s_axi_wstrb[0]) mctrl = v & 8'h0F;
    endtask : wreg

    task automatic rreg(input logic [5:0] idx);
        logic [7:0]  ev;
        logic [1:0]  er, rsp;
        logic [31:0] d;
        er = RESP_OKAY;
        ev = 8'h00;
        if (idx <= 6'h05) ev = mreg[idx];
        else if (idx == IDX_CTRL) ev = mctrl;
        else if (idx == IDX_CNT) ev = 8'(mq.size());
        else if (idx == IDX_FH && mq.size() > 0 && !mctrl[CTL_EVT]) ev = mq[0][15:8];
        else if (idx == IDX_FL && mq.size() > 0) begin
            ev = mq[0][7:0];
            mq.delete(0);
        end else if (idx != IDX_FH && idx != IDX_FL && idx != IDX_STAT) er = RESP_SLVERR;
        axi_rd(idx, d, rsp);
        `CHK("rdata", {24'h000000, ev}, d)
        `CHK("rresp", er, rsp)
    endtask : rreg

    task automatic cpu_cyc(input logic [15:0] a, input logic [7:0] d, input logic cof);
        dac_match_t em;
        logic       en;
        go <= 1'b1;
        go_addr <= a;
        go_data <= d;
        go_cof <= cof;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        en = mctrl[CTL_EN];
        em.a = en && a == {mreg[0], mreg[1]};
        em.b = en && (mctrl[CTL_FULL] ? d == mreg[3] : a == {mreg[2], mreg[3]});
        em.c = en && a == {mreg[4], mreg[5]};
        if (en && mq.size() < BUF_DEPTH && mctrl[CTL_EVT] && em.b) mq.push_back({8'h00, d});
        if (en && mq.size() < BUF_DEPTH && !mctrl[CTL_EVT] && cof) mq.push_back(a);
        @(negedge sys_clk);
        `CHK("match", em, match)
        @(posedge sys_clk);
    endtask : cpu_cyc

    task automatic do_rst(input logic por, input int cyc);
        sys_rst <= 1'b1;
        por_rst <= por;
        repeat (cyc) @(posedge sys_clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        if (por || !(mctrl[CTL_EN] && !mctrl[CTL_BEGIN])) begin
            mreg = '{RST_CAH, RST_CAL, RST_CBH, RST_CBL, RST_CCH, RST_CCL};
            mctrl = RST_CTRL;
            mq.delete();
        end
        @(posedge sys_clk);
    endtask : do_rst

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end

    initial begin
        {sys_rst, por_rst, go, go_cof, go_addr, go_data} = '1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        s_axi_arvalid = 1'b0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        go = 1'b0;
        mctrl = 8'h00;
        seed = 8'h5D;
        do_rst(1'b1, 8);
        for (int i = 0; i < 8; i++) rreg(i[5:0]);
        wreg(IDX_FH, 8'hA5);
        wreg(6'h20, 8'h77);
        rreg(IDX_FH);
        rreg(6'h20);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wreg(i[5:0], seed);
        end
        for (int i = 0; i < 6; i++) rreg(i[5:0]);
        s_axi_wstrb <= 4'hE;
        wreg(IDX_CAL, ~mreg[1]);
        s_axi_wstrb <= 4'hF;
        rreg(IDX_CAL);
        $display("test readback done");
        wreg(IDX_CTRL, 8'h01);
        for (int k = 0; k < 16; k++) cpu_cyc({mreg[0], mreg[1]} ^ (16'h0001 << k), seed, 1'b0);
        cpu_cyc({mreg[0], mreg[1]}, seed, 1'b0);
        cpu_cyc({mreg[2], mreg[3]}, seed, 1'b0);
        cpu_cyc({mreg[4], mreg[5]}, seed, 1'b0);
        cpu_cyc({mreg[4], mreg[5]} ^ 16'h0100, seed, 1'b0);
        wreg(IDX_CTRL, 8'h03);
        cpu_cyc({mreg[0], mreg[1]}, mreg[3], 1'b0);
        cpu_cyc({mreg[2], mreg[3]}, ~mreg[3], 1'b0);
        wreg(IDX_CTRL, 8'h00);
        cpu_cyc({mreg[0], mreg[1]}, seed, 1'b0);
        $display("test comparators done");
        wreg(IDX_CTRL, 8'h01);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            cpu_cyc({seed, ~seed}, seed, 1'b1);
        end
        rreg(IDX_CNT);
        rreg(IDX_STAT);
        for (int i = 0; i < 5; i++) begin
            rreg(IDX_FH);
            rreg(IDX_FL);
        end
        wreg(IDX_CTRL, 8'h05);
        cpu_cyc({mreg[2], mreg[3]}, 8'h3C, 1'b0);
        cpu_cyc({mreg[0], mreg[1]}, 8'hC3, 1'b1);
        cpu_cyc({mreg[2], mreg[3]}, 8'h96, 1'b1);
        for (int i = 0; i < 2; i++) begin
            rreg(IDX_FH);
            rreg(IDX_FL);
        end
        $display("test trace buffer done");
        wreg(IDX_CTRL, 8'h01);
        cpu_cyc(16'h1234, 8'h00, 1'b1);
        do_rst(1'b0, 1);
        for (int i = 0; i < 7; i++) rreg(i[5:0]);
        rreg(IDX_CNT);
        rreg(IDX_CTRL);
        wreg(IDX_CTRL, 8'h09);
        do_rst(1'b0, 1);
        for (int i = 0; i < 6; i++) rreg(i[5:0]);
        wreg(IDX_CTRL, 8'h01);
        wreg(IDX_CAH, 8'h5A);
        do_rst(1'b1, 1);
        rreg(IDX_CAH);
        rreg(IDX_CTRL);
        $display("test reset kinds done");
        print_verdict();
    end
endmodule : debug_address_comparators_tb
